// >>> hw/mpg_params.svh
`ifndef MPG_PARAMS_SVH
`define MPG_PARAMS_SVH

// ==========================================
// register offsets
`define MPG_ADDR_GATE_EN      8'h01
`define MPG_ADDR_GATE_ASSOC   8'h02
`define MPG_ADDR_L1_DIV       8'h09
`define MPG_ADDR_L2_DIV       8'h0a
`define MPG_ADDR_L1_PHEN      8'h0b
`define MPG_ADDR_L2_PHEN      8'h0c
`define MPG_ADDR_L1_DELOFF    8'h0d
`define MPG_ADDR_L2_DELOFF    8'h0e
`define MPG_ADDR_STATUS       8'h1f

// ==========================================
// field positions
`define MPG_EN_MSB            3
`define MPG_DEL_MSB           7
`define MPG_DEL_LSB           3
`define MPG_OFF_MSB           2
`define MPG_OFF_LSB           0

// ==========================================
// reset values
`define MPG_RST_GATE_EN       4'h0
`define MPG_RST_GATE_ASSOC    4'h0
`define MPG_RST_DIV           8'h00
`define MPG_RST_PHEN          4'h0
`define MPG_RST_DELOFF        8'h00

`endif

// >>> hw/mpg_pkg.sv
package mpg_pkg;

	// ==========================================
	// per-loop timing configuration
	typedef struct packed {
		logic [7:0] divider;
		logic [4:0] phase_delay;
		logic [2:0] off_time;
		logic [3:0] phase_en;
	} mpg_loop_cfg_s;

	// ==========================================
	// sequencer states
	typedef enum logic {
		SEQ_IDLE,
		SEQ_RUN
	} mpg_seq_e;

endpackage : mpg_pkg

// >>> hw/mpg_clk_div.sv
`timescale 1ns/1ps

module mpg_clk_div #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// divider setting and divided tick
	input  wire logic [W-1:0] divider,
	output logic              tick
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         wrap;

	// ==========================================
	// divide by setting plus one
	// R05: divide by value plus one
	assign wrap  = (cnt_q >= divider);
	assign cnt_d = wrap ? '0 : W'(cnt_q + 1'b1);
	assign tick  = wrap;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule : mpg_clk_div

// >>> hw/mpg_phase_seq.sv
`timescale 1ns/1ps

module mpg_phase_seq #(
	parameter int NPH = 4,
	parameter int IW  = 2
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// divided-clock tick and settings
	input  wire logic                  tick,
	input  mpg_pkg::mpg_loop_cfg_s     cfg,
	// internal phase outputs
	output logic [NPH-1:0]             phase_on,
	output logic                       running
);

	mpg_pkg::mpg_seq_e state_q;
	logic [IW-1:0]     cur_q;
	logic [5:0]        dly_q;
	logic [2:0]        off_q [NPH];
	logic [2:0]        off_len;
	logic              dly_done;
	logic              any_en;
	logic [IW-1:0]     nxt;

	// next enabled phase after cur, wrapping to itself
	function automatic logic [IW-1:0] next_en(input logic [IW-1:0] cur,
	                                          input logic [NPH-1:0] en);
		logic [IW-1:0] r;
		int            idx;
		r = cur;
		for (int k = NPH; k >= 1; k--) begin
			idx = (int'(cur) + k) % NPH;
			if (en[idx]) begin
				r = IW'(idx);
			end
		end
		return r;
	endfunction : next_en

	// ==========================================
	// decode
	// R09: zero off-time gives one period
	assign off_len  = (cfg.off_time == 3'h0) ? 3'h1 : cfg.off_time;
	// R08: delay is field plus one
	assign dly_done = (dly_q == {1'b0, cfg.phase_delay});
	// R12: internal phase enables
	assign any_en   = |cfg.phase_en;
	assign nxt      = next_en(cur_q, cfg.phase_en);
	assign running  = (state_q == mpg_pkg::SEQ_RUN);

	for (genvar p = 0; p < NPH; p++) begin : g_on
		assign phase_on[p] = running && cfg.phase_en[p] && (off_q[p] == 3'h0);
	end

	// ==========================================
	// delay chain and off timers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= mpg_pkg::SEQ_IDLE;
			cur_q   <= IW'(NPH - 1);
			dly_q   <= 6'h00;
			for (int p = 0; p < NPH; p++) begin
				off_q[p] <= 3'h0;
			end
		end else begin
			unique case (state_q)
				mpg_pkg::SEQ_IDLE: begin
					dly_q <= 6'h00;
					if (any_en && tick) begin
						state_q     <= mpg_pkg::SEQ_RUN;
						cur_q       <= nxt;
						off_q[nxt]  <= off_len;
					end
				end
				mpg_pkg::SEQ_RUN: begin
					if (!any_en) begin
						state_q <= mpg_pkg::SEQ_IDLE;
						cur_q   <= IW'(NPH - 1);
						for (int p = 0; p < NPH; p++) begin
							off_q[p] <= 3'h0;
						end
					end else if (tick) begin
						// R06: off time counts divided periods
						for (int p = 0; p < NPH; p++) begin
							if (off_q[p] != 3'h0) begin
								off_q[p] <= 3'(off_q[p] - 1'b1);
							end
						end
						// R07: step after delay periods
						// R10: reopen after whole chain
						if (dly_done) begin
							dly_q      <= 6'h00;
							cur_q      <= nxt;
							off_q[nxt] <= off_len;
						end else begin
							dly_q <= 6'(dly_q + 1'b1);
						end
					end
				end
			endcase
		end
	end

endmodule : mpg_phase_seq

// >>> hw/mpg_gate_timing.sv
// Function
// R01: bits 3..0 enable physical phases four..one
// R02: host writes zero to upper bits
// R03: all timing from one oscillator clock
// R04: each loop has own clock divider
// R05: divider divides by setting plus one
// R06: off time counted in divided periods
// R07: phase delay counted in divided periods
// R08: phase delay field plus one periods
// R09: off time zero gives one period
// R10: reopen only after all phase delays
// R11: host keeps delay near 32 periods
// R12: internal phase enables set chain length
// R13: disabled physical phase holds gate off
`timescale 1ns/1ps
`include "mpg_params.svh"

module mpg_gate_timing #(
	parameter int NPH = 4
) (
	// clock and reset
	input  wire logic           CLOCK,
	input  wire logic           RST,
	// register port
	input  wire logic [7:0]     REG_ADDR,
	input  wire logic           REG_WRITE,
	input  wire logic [7:0]     REG_WDATA,
	input  wire logic           REG_READ,
	output logic      [7:0]     REG_RDATA,
	// gate drive outputs
	output logic      [NPH-1:0] GATE_DRIVE
);

	// ==========================================
	// register storage
	logic [3:0]             gate_phase_enable_q;
	logic [3:0]             gate_assoc_q;
	logic [7:0]             loop1_divider_q;
	logic [7:0]             loop2_divider_q;
	logic [3:0]             loop1_phen_q;
	logic [3:0]             loop2_phen_q;
	logic [7:0]             loop1_delay_offtime_q;
	logic [7:0]             loop2_delay_offtime_q;
	logic [7:0]             rdata_q;
	logic [7:0]             rdata_d;
	logic [NPH-1:0]         gate_q;
	logic [NPH-1:0]         gate_d;

	// ==========================================
	// address decode
	logic                   wr_gate_en;
	logic                   wr_assoc;
	logic                   wr_l1_div;
	logic                   wr_l2_div;
	logic                   wr_l1_phen;
	logic                   wr_l2_phen;
	logic                   wr_l1_do;
	logic                   wr_l2_do;

	assign wr_gate_en = REG_WRITE && (REG_ADDR == `MPG_ADDR_GATE_EN);
	assign wr_assoc   = REG_WRITE && (REG_ADDR == `MPG_ADDR_GATE_ASSOC);
	assign wr_l1_div  = REG_WRITE && (REG_ADDR == `MPG_ADDR_L1_DIV);
	assign wr_l2_div  = REG_WRITE && (REG_ADDR == `MPG_ADDR_L2_DIV);
	assign wr_l1_phen = REG_WRITE && (REG_ADDR == `MPG_ADDR_L1_PHEN);
	assign wr_l2_phen = REG_WRITE && (REG_ADDR == `MPG_ADDR_L2_PHEN);
	assign wr_l1_do   = REG_WRITE && (REG_ADDR == `MPG_ADDR_L1_DELOFF);
	assign wr_l2_do   = REG_WRITE && (REG_ADDR == `MPG_ADDR_L2_DELOFF);

	// ==========================================
	// register writes
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			gate_phase_enable_q   <= `MPG_RST_GATE_EN;
			gate_assoc_q          <= `MPG_RST_GATE_ASSOC;
			loop1_divider_q       <= `MPG_RST_DIV;
			loop2_divider_q       <= `MPG_RST_DIV;
			loop1_phen_q          <= `MPG_RST_PHEN;
			loop2_phen_q          <= `MPG_RST_PHEN;
			loop1_delay_offtime_q <= `MPG_RST_DELOFF;
			loop2_delay_offtime_q <= `MPG_RST_DELOFF;
		end else begin
			// R01: one enable bit per phase
			// R02: reserved upper bits not stored
			if (wr_gate_en) begin
				gate_phase_enable_q <= REG_WDATA[`MPG_EN_MSB:0];
			end
			if (wr_assoc) begin
				gate_assoc_q <= REG_WDATA[`MPG_EN_MSB:0];
			end
			if (wr_l1_div) begin
				loop1_divider_q <= REG_WDATA;
			end
			if (wr_l2_div) begin
				loop2_divider_q <= REG_WDATA;
			end
			if (wr_l1_phen) begin
				loop1_phen_q <= REG_WDATA[`MPG_EN_MSB:0];
			end
			if (wr_l2_phen) begin
				loop2_phen_q <= REG_WDATA[`MPG_EN_MSB:0];
			end
			// R11: delay value taken as written
			if (wr_l1_do) begin
				loop1_delay_offtime_q <= REG_WDATA;
			end
			if (wr_l2_do) begin
				loop2_delay_offtime_q <= REG_WDATA;
			end
		end
	end

	// ==========================================
	// loop configuration
	mpg_pkg::mpg_loop_cfg_s cfg1;
	mpg_pkg::mpg_loop_cfg_s cfg2;

	assign cfg1.divider     = loop1_divider_q;
	assign cfg1.phase_delay = loop1_delay_offtime_q[`MPG_DEL_MSB:`MPG_DEL_LSB];
	assign cfg1.off_time    = loop1_delay_offtime_q[`MPG_OFF_MSB:`MPG_OFF_LSB];
	assign cfg1.phase_en    = loop1_phen_q;
	assign cfg2.divider     = loop2_divider_q;
	assign cfg2.phase_delay = loop2_delay_offtime_q[`MPG_DEL_MSB:`MPG_DEL_LSB];
	assign cfg2.off_time    = loop2_delay_offtime_q[`MPG_OFF_MSB:`MPG_OFF_LSB];
	assign cfg2.phase_en    = loop2_phen_q;

	// ==========================================
	// divided clocks, one per loop
	logic                   tick1;
	logic                   tick2;

	// R03: both dividers run on CLOCK
	// R04: separate divider per loop
	mpg_clk_div #(
		.W       (8)
	) u_div1 (
		.clock   (CLOCK),
		.rst     (RST),
		.divider (cfg1.divider),
		.tick    (tick1)
	);

	mpg_clk_div #(
		.W       (8)
	) u_div2 (
		.clock   (CLOCK),
		.rst     (RST),
		.divider (cfg2.divider),
		.tick    (tick2)
	);

	// ==========================================
	// phase sequencers
	logic [NPH-1:0]         on1;
	logic [NPH-1:0]         on2;
	logic                   run1;
	logic                   run2;

	mpg_phase_seq #(
		.NPH      (NPH),
		.IW       (2)
	) u_seq1 (
		.clock    (CLOCK),
		.rst      (RST),
		.tick     (tick1),
		.cfg      (cfg1),
		.phase_on (on1),
		.running  (run1)
	);

	mpg_phase_seq #(
		.NPH      (NPH),
		.IW       (2)
	) u_seq2 (
		.clock    (CLOCK),
		.rst      (RST),
		.tick     (tick2),
		.cfg      (cfg2),
		.phase_on (on2),
		.running  (run2)
	);

	// ==========================================
	// gate drive, per physical phase
	for (genvar g = 0; g < NPH; g++) begin : g_gate
		// R13: disabled phase held off
		assign gate_d[g] = gate_phase_enable_q[g] && (gate_assoc_q[g] ? on2[g] : on1[g]);
	end

	// ==========================================
	// read mux
	logic [7:0]             status;

	assign status = {2'b00, run2, run1, gate_q};

	always_comb begin
		rdata_d = rdata_q;
		if (REG_READ) begin
			unique case (REG_ADDR)
				`MPG_ADDR_GATE_EN:    rdata_d = {4'h0, gate_phase_enable_q};
				`MPG_ADDR_GATE_ASSOC: rdata_d = {4'h0, gate_assoc_q};
				`MPG_ADDR_L1_DIV:     rdata_d = loop1_divider_q;
				`MPG_ADDR_L2_DIV:     rdata_d = loop2_divider_q;
				`MPG_ADDR_L1_PHEN:    rdata_d = {4'h0, loop1_phen_q};
				`MPG_ADDR_L2_PHEN:    rdata_d = {4'h0, loop2_phen_q};
				`MPG_ADDR_L1_DELOFF:  rdata_d = loop1_delay_offtime_q;
				`MPG_ADDR_L2_DELOFF:  rdata_d = loop2_delay_offtime_q;
				`MPG_ADDR_STATUS:     rdata_d = status;
				default:              rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			rdata_q <= 8'h00;
			gate_q  <= '0;
		end else begin
			rdata_q <= rdata_d;
			gate_q  <= gate_d;
		end
	end

	assign REG_RDATA  = rdata_q;
	assign GATE_DRIVE = gate_q;

endmodule : mpg_gate_timing

// >>> test/mpg_gate_timing_properties.sv
`timescale 1ns/1ps

module mpg_gate_timing_properties #(
	parameter int NPH = 4
) (
	input wire logic           CLOCK,
	input wire logic           RST,
	input wire logic [7:0]     REG_ADDR,
	input wire logic           REG_WRITE,
	input wire logic [7:0]     REG_WDATA,
	input wire logic           REG_READ,
	input wire logic [7:0]     REG_RDATA,
	input wire logic [NPH-1:0] GATE_DRIVE
);
	// ==========================
	// register mirror, gate one timing
	logic [7:0]  m_q [16];
	logic [15:0] quiet_q, rise_q, fall_q;
	logic        g_q;
	int          tk, sl, np, per, offl;
	wire         sel  = m_q[2][0];
	wire  [7:0]  rexp = (REG_ADDR == 8'h01) ? {4'h0, m_q[1][3:0]} : m_q[REG_ADDR[3:0]];
	assign tk   = m_q[9 + sel] + 1;
	assign sl   = m_q[13 + sel][7:3] + 1;
	assign np   = $countones(m_q[11 + sel][3:0]);
	assign per  = tk * sl * np;
	assign offl = (m_q[13 + sel][2:0] == 3'h0) ? 1 : int'(m_q[13 + sel][2:0]);

	function automatic logic [15:0] sat(input logic [15:0] v);
		return (&v) ? v : v + 16'h1;
	endfunction : sat

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			m_q     <= '{default: 8'h00};
			quiet_q <= 16'h0;
			rise_q  <= 16'h0;
			fall_q  <= 16'h0;
			g_q     <= 1'b0;
		end else begin
			if (REG_WRITE && REG_ADDR[7:4] == 4'h0)
				m_q[REG_ADDR[3:0]] <= REG_WDATA;
			quiet_q <= REG_WRITE ? 16'h0 : sat(quiet_q);
			rise_q  <= (GATE_DRIVE[0] && !g_q) ? 16'h1 : sat(rise_q);
			fall_q  <= (!GATE_DRIVE[0] && g_q) ? 16'h1 : sat(fall_q);
			g_q     <= GATE_DRIVE[0];
		end
	end

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	// ==========================
	// assertions
	a_gate_en_read:
	assert property (REG_READ && REG_ADDR == 8'h01 |=> REG_RDATA == $past(rexp))
		else $error("gate enable read back wrong");
	a_divider_read:
	assert property (REG_READ && REG_ADDR inside {8'h09, 8'h0a} |=> REG_RDATA == $past(rexp))
		else $error("divider read back wrong");
	a_delay_read:
	assert property (REG_READ && REG_ADDR inside {8'h0d, 8'h0e} |=> REG_RDATA == $past(rexp))
		else $error("delay and off time read back wrong");
	a_unmapped_zero:
	assert property (REG_READ && REG_ADDR[7:5] != 3'h0 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_gate_masked:
	assert property ((GATE_DRIVE & ~$past(m_q[1][NPH-1:0])) == '0)
		else $error("disabled gate driven");
	a_idle_gate_off:
	assert property (quiet_q > 16'h2 && np == 0 |-> !GATE_DRIVE[0])
		else $error("gate on with no internal phase");
	a_slot_period:
	assert property ($rose(GATE_DRIVE[0]) && quiet_q > 2 * per + 8 |-> rise_q == per)
		else $error("gate period wrong");
	a_off_width:
	assert property ($rose(GATE_DRIVE[0]) && quiet_q > 2 * per + 8 |-> fall_q == offl * tk)
		else $error("gate off time wrong");

	c_gate_rise: cover property ($rose(GATE_DRIVE[0]) && quiet_q > 2 * per + 8);
	c_all_gates: cover property (&GATE_DRIVE);
	c_unmapped: cover property (REG_READ && REG_ADDR[7:5] != 3'h0);
endmodule : mpg_gate_timing_properties

// >>> test/mpg_fet_stage_model.sv
`timescale 1ns/1ps

// ==========================
// switch stages: count turn-on events
module mpg_fet_stage_model #(
	parameter int NPH = 4
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// gate drive and turn-on counts
	input  wire logic [NPH-1:0]       gate,
	output logic      [NPH-1:0][15:0] turn_ons
);
	logic [NPH-1:0] prev_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prev_q   <= '0;
			turn_ons <= '0;
		end else begin
			prev_q <= gate;
			for (int g = 0; g < NPH; g++) begin
				if (gate[g] && !prev_q[g])
					turn_ons[g] <= turn_ons[g] + 16'h1;
			end
		end
	end
endmodule : mpg_fet_stage_model

// >>> test/mpg_gate_timing_tb.sv
`timescale 1ns/1ps

module mpg_gate_timing_tb;
	logic             CLOCK, RST, REG_WRITE, REG_READ;
	logic [7:0]       REG_ADDR, REG_WDATA, REG_RDATA, d;
	logic [3:0]       GATE_DRIVE, en, ph, as;
	logic [3:0][15:0] ons, ons0;
	logic [31:0]      r, rng = 32'h3bf1;
	logic [7:0]       exp_q [$];
	logic [7:0]       regs [8] = '{8'h01, 8'h02, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
	logic             rd_seen = 1'b0;
	int               errors = 0, n_compared = 0, p [2], w, k, e;

	mpg_gate_timing dut (.CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE),
		.REG_WDATA(REG_WDATA), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
		.GATE_DRIVE(GATE_DRIVE));
	mpg_fet_stage_model model (.clock(CLOCK), .rst(RST), .gate(GATE_DRIVE), .turn_ons(ons));

	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end

	function automatic logic [31:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : nxt

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_compared++;
		if (seen !== want) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// one register access, expected read value noted for the monitor
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] v);
		@(negedge CLOCK);
		REG_ADDR  = a;
		REG_WDATA = v;
		REG_WRITE = wr;
		REG_READ  = !wr;
		if (!wr)
			exp_q.push_back(v);
		@(negedge CLOCK);
		REG_WRITE = 1'b0;
		REG_READ  = 1'b0;
	endtask : acc

	always @(posedge CLOCK) rd_seen <= REG_READ;
	always @(negedge CLOCK) begin
		if (rd_seen && exp_q.size() > 0)
			check({8'h00, REG_RDATA}, {8'h00, exp_q.pop_front()});
	end

	initial begin
		repeat (100000) @(posedge CLOCK);
		errors++;
		end_of_test();
	end

	initial begin
		RST = 1'b1;
		{REG_WRITE, REG_READ, REG_ADDR, REG_WDATA} = '0;
		repeat (8) @(negedge CLOCK);
		RST = 1'b0;
		for (int i = 0; i < 8; i++) begin
			r = nxt();
			d = r[7:0] & ((regs[i] inside {8'h01, 8'h02, 8'h0b, 8'h0c}) ? 8'h0f : 8'hff);
			acc(1'b1, regs[i], d);
			acc(1'b0, regs[i], d);
		end
		acc(1'b0, 8'h25, 8'h00);
		for (int it = 0; it < 5; it++) begin
			r  = nxt();
			ph = r[7:4] | 4'h1;
			en = r[11:8];
			as = r[15:12];
			k  = (it == 0) ? 31 : 7;
			if (it == 0)
				r[19:16] = 4'h0;
			acc(1'b1, 8'h01, {4'h0, en});
			acc(1'b1, 8'h02, {4'h0, as});
			acc(1'b1, 8'h0b, {4'h0, ph});
			acc(1'b1, 8'h0c, {4'h0, ph[2:0], ph[3]});
			acc(1'b1, 8'h09, {7'h0, r[16]});
			acc(1'b1, 8'h0a, {7'h0, r[17]});
			acc(1'b1, 8'h0d, {5'(k + r[18]), r[2:0]});
			acc(1'b1, 8'h0e, {5'(k + r[19]), r[22:20]});
			p[0] = (r[16] + 1) * (k + r[18] + 1) * $countones(ph);
			p[1] = (r[17] + 1) * (k + r[19] + 1) * $countones(ph);
			w = (p[0] == p[1]) ? 4 * p[0] : p[0] * p[1];
			repeat (w + 300) @(negedge CLOCK);
			ons0 = ons;
			repeat (w) @(negedge CLOCK);
			for (int g = 0; g < 4; g++) begin
				e = (as[g] ? ph[(g + 3) % 4] : ph[g]) ? w / p[as[g]] : 0;
				if (en[g])
					check(ons[g] - ons0[g], 16'(e));
				else
					check(ons[g] - ons0[g], 16'h0);
			end
		end
		RST = 1'b1;
		@(negedge CLOCK);
		check({12'h0, GATE_DRIVE}, 16'h0);
		RST = 1'b0;
		acc(1'b0, 8'h0d, 8'h00);
		acc(1'b0, 8'h1f, 8'h00);
		@(negedge CLOCK);
		end_of_test();
	end
endmodule : mpg_gate_timing_tb

bind mpg_gate_timing mpg_gate_timing_properties #(.NPH(NPH)) props (.CLOCK(CLOCK), .RST(RST),
	.REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE), .REG_WDATA(REG_WDATA), .REG_READ(REG_READ),
	.REG_RDATA(REG_RDATA), .GATE_DRIVE(GATE_DRIVE));
